/* File: inc/serial_cfg_pkg.sv */
// serial port configuration and system clock pll register bank constants
// assumes: 16-bit instruction serial port, 8-bit registers, 13-bit address
package serial_cfg_pkg;

   // ****************************************
   // framing
   // ****************************************
   localparam int BYTE_W = 8;
   localparam int INSTR_W = 16;
   localparam int ADDR_W = 13;
   localparam int RW_BIT = 15;

   // ****************************************
   // register offsets
   // ****************************************
   localparam logic [ADDR_W-1:0] ADR_SERIAL_CFG = 13'h0000;
   localparam logic [ADDR_W-1:0] ADR_RESERVED = 13'h0001;
   localparam logic [ADDR_W-1:0] ADR_SILICON_REV = 13'h0002;
   localparam logic [ADDR_W-1:0] ADR_PART_ID = 13'h0003;
   localparam logic [ADDR_W-1:0] ADR_READBACK = 13'h0004;
   localparam logic [ADDR_W-1:0] ADR_XFER_STROBE = 13'h0005;
   localparam logic [ADDR_W-1:0] ADR_PLL_PUMP_LOCK = 13'h0100;
   localparam logic [ADDR_W-1:0] ADR_PLL_FB_RATIO = 13'h0101;

   // ****************************************
   // field positions
   // ****************************************
   localparam int CFG_FOUR_WIRE = 7;
   localparam int CFG_LSB_FIRST = 6;
   localparam int CFG_SOFT_RESET = 5;
   localparam int CFG_LONG_INSTR = 4;
   localparam int RB_SEL_BUFFER = 0;
   localparam int XFER_GO = 0;
   localparam int PLL_EXT_FILTER = 7;
   localparam int PLL_PUMP_MANUAL = 6;
   localparam int PLL_PUMP_CUR_HI = 5;
   localparam int PLL_PUMP_CUR_LO = 3;
   localparam int PLL_LOCK_OFF = 2;
   localparam int PLL_LOCK_DEPTH_HI = 1;
   localparam int PLL_LOCK_DEPTH_LO = 0;

   // ****************************************
   // reset values
   // ****************************************
   localparam logic [BYTE_W-1:0] PLL_PUMP_LOCK_RST = 8'h18;
   localparam logic [BYTE_W-1:0] PLL_FB_RATIO_RST = 8'h28;
   localparam logic [BYTE_W-1:0] ZERO_BYTE = 8'h00;

endpackage

/* File: src/pin_sync.sv */
// two flip-flop synchroniser for the serial and multifunction pins
// assumes: inputs are asynchronous to ref_clk; reset value chosen per bit
`timescale 1ns/1ps
module pin_sync import serial_cfg_pkg::*; #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic clk_en,
   // pins and synchronised copy
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   if (WIDTH < 1) begin : g_chk
      $error("pin_sync needs WIDTH of at least 1");
   end

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } sync_t;

   sync_t s_q, s_d;

   // the first stage feeds only the second
   always_comb begin
      s_d = s_q;
      s_d.meta = async_in;
      s_d.stable = s_q.meta;
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_q <= '{meta: RST_VAL, stable: RST_VAL};
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   assign sync_out = s_q.stable;

endmodule

/* File: src/serial_shifter.sv */
// serial bit engine: assembles received bytes and shifts read data out
// assumes: rise/fall are one-cycle pulses of the synchronised serial clock
`timescale 1ns/1ps
module serial_shifter import serial_cfg_pkg::*; #(
   parameter int WIDTH = BYTE_W
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic clk_en,
   // serial clock events
   input wire logic start,
   input wire logic rise,
   input wire logic fall,
   input wire logic din,
   input wire logic lsb_first,
   // receive side
   output logic byte_done,
   output logic [WIDTH-1:0] rx_byte,
   // transmit side
   input wire logic load,
   input wire logic [WIDTH-1:0] load_data,
   output logic tx_bit
);

   localparam int CW = $clog2(WIDTH);

   if (WIDTH < 2) begin : g_chk
      $error("serial_shifter needs WIDTH of at least 2");
   end

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic [WIDTH-1:0] rx;
      logic [WIDTH-1:0] tx;
      logic bit_o;
      logic done;
   } shift_t;

   shift_t s_q, s_d;

   always_comb begin
      s_d = s_q;
      s_d.done = 1'b0;
      if (start) begin
         s_d.cnt = '0;
      end
      if (rise) begin
         s_d.rx = lsb_first ? {din, s_q.rx[WIDTH-1:1]} : {s_q.rx[WIDTH-2:0], din};
         s_d.done = (s_q.cnt == CW'(WIDTH - 1));
         s_d.cnt = s_d.done ? '0 : s_q.cnt + 1'b1;
      end
      // no shift on the fall that opens a byte: a fresh load already shows its first bit
      if (load) begin
         s_d.tx = load_data;
         s_d.bit_o = lsb_first ? load_data[0] : load_data[WIDTH-1];
      end else if (fall && s_q.cnt != '0) begin
         s_d.tx = lsb_first ? {1'b0, s_q.tx[WIDTH-1:1]} : {s_q.tx[WIDTH-2:0], 1'b0};
         s_d.bit_o = lsb_first ? s_q.tx[1] : s_q.tx[WIDTH-2];
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_q <= '0;
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   assign byte_done = s_q.done;
   assign rx_byte = s_q.rx;
   assign tx_bit = s_q.bit_o;

   property p_first_bit;
      @(posedge ref_clk) disable iff (!arst_n || !clk_en)
      load |=> tx_bit == ($past(lsb_first) ? $past(load_data[0]) : $past(load_data[WIDTH-1]));
   endproperty
   a_first_bit: assert property (p_first_bit) else $error("first read bit in wrong order");

endmodule

/* File: src/serial_cfg_and_system_timebase_input_pll_regs.sv */
// serial-port reached register bank: port setup, identity, readback,
// buffered system clock pll controls with a transfer strobe
// assumes: host uses 16-bit instructions, serial clock phases last 8+ ref_clk
//
// What this block does
// - bit 7 picks three-wire or four-wire SDO
// - bit 6 picks msb-first or lsb-first order
// - bit 5 resets bank, starts NVM load only if a multifunction pin 7..3 is high
// - bit 4 reads one; only 16-bit instructions
// - read-only silicon revision code at 0x0002
// - read-only part identity code at 0x0003
// - readback select: active or buffered values
// - transfer strobe copies buffers, then self-clears
// - bit 7 selects internal or external filter
// - charge pump auto/manual, 3-bit current code
// - bit 2 disables the lock detect timer
// - bits 1:0 pick lock timer depth
// - feedback divide ratio, default 40, 6..255
`timescale 1ns/1ps
module serial_cfg_and_system_timebase_input_pll_regs import serial_cfg_pkg::*; #(
   // arbitrary neutral values, not any real part's codes
   parameter logic [BYTE_W-1:0] REVISION_CODE = 8'h5a,
   parameter logic [BYTE_W-1:0] PART_CODE = 8'ha5
) (
   // clock, reset, enable
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic clk_en,
   // serial port pins
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdio_i,
   output logic sdio_o,
   output logic sdio_oe,
   output logic sdo_o,
   output logic sdo_oe,
   // multifunction pins 7 down to 3
   input wire logic [4:0] mf_pins_hi,
   // device reset and nonvolatile download
   output logic soft_reset_pulse,
   output logic nvm_download_start,
   // serial port mode as applied
   output logic four_wire_mode,
   output logic lsb_first_mode,
   // system clock pll controls (active copies)
   output logic ext_loop_filter,
   output logic pump_manual,
   output logic [2:0] pump_current_code,
   output logic lock_timer_off,
   output logic [1:0] lock_timer_depth,
   output logic [BYTE_W-1:0] fb_divide
);

   // ****************************************
   // types and state
   // ****************************************
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_INSTR0 = 2'b01,
      ST_INSTR1 = 2'b10,
      ST_DATA = 2'b11
   } frame_st_t;

   typedef struct packed {
      frame_st_t st;
      logic [BYTE_W-1:0] first;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic load;
      logic frame_lsb;
      logic four_wire;
      logic lsb_first;
      logic srst;
      logic nvm;
      logic rb_buf;
      logic upd;
      logic [BYTE_W-1:0] pll_buf;
      logic [BYTE_W-1:0] pll_act;
      logic [BYTE_W-1:0] div_buf;
      logic [BYTE_W-1:0] div_act;
      logic sclk_p;
      logic cs_p;
   } bank_t;

   localparam bank_t BANK_RST = '{
      st: ST_IDLE,
      first: ZERO_BYTE,
      rd: 1'b0,
      addr: '0,
      load: 1'b0,
      frame_lsb: 1'b0,
      four_wire: 1'b0,
      lsb_first: 1'b0,
      srst: 1'b0,
      nvm: 1'b0,
      rb_buf: 1'b0,
      upd: 1'b0,
      pll_buf: PLL_PUMP_LOCK_RST,
      pll_act: PLL_PUMP_LOCK_RST,
      div_buf: PLL_FB_RATIO_RST,
      div_act: PLL_FB_RATIO_RST,
      sclk_p: 1'b0,
      cs_p: 1'b1
   };

   bank_t s_q, s_d;

   // ****************************************
   // pin synchronisers
   // ****************************************
   logic [7:0] pins_s;
   logic sclk_s;
   logic cs_s;
   logic sdio_s;
   logic [4:0] mf_s;

   pin_sync #(
      .WIDTH(8),
      .RST_VAL(8'h02)
   ) u_sync (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .clk_en(clk_en),
      .async_in({mf_pins_hi, sdio_i, cs_n, sclk}),
      .sync_out(pins_s)
   );

   assign sclk_s = pins_s[0];
   assign cs_s = pins_s[1];
   assign sdio_s = pins_s[2];
   assign mf_s = pins_s[7:3];

   // ****************************************
   // readback decode
   // ****************************************
   function automatic logic [BYTE_W-1:0] rd_mux(input logic [ADDR_W-1:0] a, input bank_t b);
      logic [BYTE_W-1:0] v;
      v = ZERO_BYTE;
      unique case (a)
         ADR_SERIAL_CFG: begin
            v[CFG_FOUR_WIRE] = b.four_wire;
            v[CFG_LSB_FIRST] = b.lsb_first;
            v[CFG_SOFT_RESET] = b.srst;
            v[CFG_LONG_INSTR] = 1'b1;
         end
         ADR_SILICON_REV: v = REVISION_CODE;
         ADR_PART_ID: v = PART_CODE;
         ADR_READBACK: v[RB_SEL_BUFFER] = b.rb_buf;
         ADR_XFER_STROBE: v[XFER_GO] = b.upd;
         ADR_PLL_PUMP_LOCK: v = b.rb_buf ? b.pll_buf : b.pll_act;
         ADR_PLL_FB_RATIO: v = b.rb_buf ? b.div_buf : b.div_act;
         default: v = ZERO_BYTE;
      endcase
      return v;
   endfunction

   // ****************************************
   // serial bit engine
   // ****************************************
   logic active;
   logic rise;
   logic fall;
   logic cs_fall;
   logic byte_done;
   logic [BYTE_W-1:0] rx_byte;
   logic [BYTE_W-1:0] tx_data;
   logic tx_bit;

   assign active = (s_q.st != ST_IDLE) && !cs_s;
   assign rise = active && sclk_s && !s_q.sclk_p;
   assign fall = active && !sclk_s && s_q.sclk_p;
   assign cs_fall = !cs_s && s_q.cs_p;
   assign tx_data = rd_mux(s_q.addr, s_q);

   serial_shifter #(
      .WIDTH(BYTE_W)
   ) u_shift (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .clk_en(clk_en),
      .start(cs_fall),
      .rise(rise),
      .fall(fall),
      .din(sdio_s),
      .lsb_first(s_q.frame_lsb),
      .byte_done(byte_done),
      .rx_byte(rx_byte),
      .load(s_q.load),
      .load_data(tx_data),
      .tx_bit(tx_bit)
   );

   // ****************************************
   // frame and register update
   // ****************************************
   always_comb begin
      logic [INSTR_W-1:0] instr;
      instr = '0;
      s_d = s_q;
      s_d.load = 1'b0;
      if (s_q.srst) begin
         // whole bank back to defaults; edge history kept to avoid a false frame start
         s_d = BANK_RST;
      end else begin
         if (s_q.upd) begin
            s_d.pll_act = s_q.pll_buf;
            s_d.div_act = s_q.div_buf;
            s_d.upd = 1'b0;
         end
         if (cs_s) begin
            s_d.st = ST_IDLE;
         end else if (cs_fall) begin
            // order frozen per frame so a mode write cannot tear the frame
            s_d.st = ST_INSTR0;
            s_d.frame_lsb = s_q.lsb_first;
         end else if (byte_done) begin
            unique case (s_q.st)
               ST_INSTR0: begin
                  s_d.first = rx_byte;
                  s_d.st = ST_INSTR1;
               end
               ST_INSTR1: begin
                  // fixed 16-bit instruction: r/w, two length bits, address
                  instr = s_q.frame_lsb ? {rx_byte, s_q.first} : {s_q.first, rx_byte};
                  s_d.rd = instr[RW_BIT];
                  s_d.addr = instr[ADDR_W-1:0];
                  s_d.load = instr[RW_BIT];
                  s_d.st = ST_DATA;
               end
               ST_DATA: begin
                  if (!s_q.rd) begin
                     unique case (s_q.addr)
                        ADR_SERIAL_CFG: begin
                           s_d.four_wire = rx_byte[CFG_FOUR_WIRE];
                           s_d.lsb_first = rx_byte[CFG_LSB_FIRST];
                           s_d.srst = rx_byte[CFG_SOFT_RESET];
                           s_d.nvm = rx_byte[CFG_SOFT_RESET] && (mf_s != '0);
                        end
                        ADR_READBACK: s_d.rb_buf = rx_byte[RB_SEL_BUFFER];
                        // a new strobe beats the clear of the previous one
                        ADR_XFER_STROBE: s_d.upd = s_d.upd | rx_byte[XFER_GO];
                        ADR_PLL_PUMP_LOCK: s_d.pll_buf = rx_byte;
                        ADR_PLL_FB_RATIO: s_d.div_buf = rx_byte;
                        default: s_d.rd = 1'b0;
                     endcase
                  end
                  // streaming walks upward in lsb-first order, downward otherwise
                  s_d.addr = s_q.frame_lsb ? s_q.addr + 1'b1 : s_q.addr - 1'b1;
                  s_d.load = s_q.rd;
               end
               ST_IDLE: s_d.st = ST_IDLE;
            endcase
         end
      end
      s_d.sclk_p = sclk_s;
      s_d.cs_p = cs_s;
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_q <= BANK_RST;
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   logic reading;

   assign reading = (s_q.st == ST_DATA) && s_q.rd && !cs_s;
   assign sdio_o = tx_bit;
   assign sdo_o = tx_bit;
   assign sdio_oe = reading && !s_q.four_wire;
   assign sdo_oe = reading && s_q.four_wire;
   assign soft_reset_pulse = s_q.srst;
   assign nvm_download_start = s_q.nvm;
   assign four_wire_mode = s_q.four_wire;
   assign lsb_first_mode = s_q.lsb_first;
   assign ext_loop_filter = s_q.pll_act[PLL_EXT_FILTER];
   assign pump_manual = s_q.pll_act[PLL_PUMP_MANUAL];
   assign pump_current_code = s_q.pll_act[PLL_PUMP_CUR_HI:PLL_PUMP_CUR_LO];
   assign lock_timer_off = s_q.pll_act[PLL_LOCK_OFF];
   assign lock_timer_depth = s_q.pll_act[PLL_LOCK_DEPTH_HI:PLL_LOCK_DEPTH_LO];
   assign fb_divide = s_q.div_act;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n || !clk_en);

   logic [BYTE_W-1:0] cfg_view;
   assign cfg_view = rd_mux(ADR_SERIAL_CFG, s_q);

   logic pll_act_ok;
   logic div_act_ok;
   logic [BYTE_W-1:0] pll_buf_p;
   logic [BYTE_W-1:0] div_buf_p;

   sequence s_strobe;
      s_q.upd && !s_q.srst;
   endsequence

   sequence s_copied;
      ##1 (pll_act_ok && div_act_ok);
   endsequence

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         pll_buf_p <= PLL_PUMP_LOCK_RST;
         div_buf_p <= PLL_FB_RATIO_RST;
      end else if (clk_en) begin
         pll_buf_p <= s_q.pll_buf;
         div_buf_p <= s_q.div_buf;
      end
   end

   assign pll_act_ok = (s_q.pll_act == pll_buf_p);
   assign div_act_ok = (fb_divide == div_buf_p);

   property p_update_copies;
      s_strobe |-> s_copied;
   endproperty
   a_update_copies: assert property (p_update_copies) else $error("strobe did not copy buffers");

   property p_update_clears;
      s_q.upd && !(byte_done && s_q.st == ST_DATA) |=> !s_q.upd;
   endproperty
   a_update_clears: assert property (p_update_clears) else $error("transfer strobe did not clear");

   property p_long_instr;
      cfg_view[CFG_LONG_INSTR] && cfg_view[3:0] == 4'h0;
   endproperty
   a_long_instr: assert property (p_long_instr) else $error("config readback bits wrong");

   property p_wire_mode;
      !(sdio_oe && sdo_oe) && (!sdo_oe || four_wire_mode);
   endproperty
   a_wire_mode: assert property (p_wire_mode) else $error("read data on wrong pin");

   property p_soft_reset;
      s_q.srst |=> fb_divide == PLL_FB_RATIO_RST && s_q.pll_act == PLL_PUMP_LOCK_RST && !s_q.srst;
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("soft reset left state");

   property p_nvm_start;
      nvm_download_start |-> soft_reset_pulse ##1 !nvm_download_start;
   endproperty
   a_nvm_start: assert property (p_nvm_start) else $error("download without reset");

   property p_id_codes;
      s_q.load |-> (s_q.addr != ADR_SILICON_REV || tx_data == REVISION_CODE)
         && (s_q.addr != ADR_PART_ID || tx_data == PART_CODE);
   endproperty
   a_id_codes: assert property (p_id_codes) else $error("identity readback wrong");

   property p_readback_src;
      s_q.load && s_q.addr == ADR_PLL_FB_RATIO |->
         tx_data == (s_q.rb_buf ? s_q.div_buf : fb_divide);
   endproperty
   a_readback_src: assert property (p_readback_src) else $error("readback source wrong");

   property p_unused_zero;
      s_q.load && s_q.addr == ADR_READBACK |-> tx_data[BYTE_W-1:1] == 7'h00;
   endproperty
   a_unused_zero: assert property (p_unused_zero) else $error("unused bits not zero");

endmodule

/* File: dv/spi_host_model.sv */
// host controller model: frames 16-bit instructions and data on the serial pins
// assumes: ref_clk at 40 MHz; sclk phases of 10 ref_clk; sdio has no pull
`timescale 1ns/1ps
module spi_host_model import serial_cfg_pkg::*; (
   // clock
   input wire logic ref_clk,
   // serial port pins
   output logic sclk,
   output logic cs_n,
   output logic sdio_line,
   input wire logic sdio_o,
   input wire logic sdio_oe,
   input wire logic sdo_o,
   input wire logic sdo_oe
);
   // ****************************************
   // wire level and frame engine
   // ****************************************
   logic lsb = 1'b0;
   logic four = 1'b0;
   logic host_d = 1'b0;
   logic host_oe = 1'b1;
   logic [BYTE_W-1:0] tx_q[$];
   logic [BYTE_W:0] rx_q[$];
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
   end
   assign sdio_line = sdio_oe ? sdio_o : host_d;
   // released line: keep it moving so a stale level never reads as data
   always @(posedge ref_clk) if (!host_oe) host_d <= ~host_d;

   task automatic bit_x(input logic b, input logic rel, output logic g, output logic oe);
      if (host_oe) host_d <= b;
      repeat (10) @(posedge ref_clk);
      sclk <= 1'b1;
      g = four ? sdo_o : sdio_line;
      oe = four ? sdo_oe : sdio_oe;
      repeat (2) @(posedge ref_clk);
      if (rel) host_oe <= 1'b0;
      repeat (8) @(posedge ref_clk);
      sclk <= 1'b0;
   endtask

   task automatic frame(input logic rd, input logic [ADDR_W-1:0] adr, input int n);
      logic [INSTR_W-1:0] ins;
      logic [BYTE_W-1:0] b;
      logic g, oe, oe_all;
      ins = {rd, 2'b00, adr};
      cs_n <= 1'b0;
      repeat (4) @(posedge ref_clk);
      for (int i = 0; i < INSTR_W; i++) begin
         bit_x(lsb ? ins[i] : ins[INSTR_W-1-i], rd && !four && i == INSTR_W-1, g, oe);
      end
      for (int k = 0; k < n; k++) begin
         b = rd ? 8'h00 : tx_q.pop_front();
         oe_all = 1'b1;
         for (int i = 0; i < BYTE_W; i++) begin
            bit_x(lsb ? b[i] : b[BYTE_W-1-i], 1'b0, g, oe);
            if (lsb) b[i] = g;
            else b[BYTE_W-1-i] = g;
            oe_all = oe_all & oe;
         end
         if (rd) rx_q.push_back({oe_all, b});
      end
      repeat (10) @(posedge ref_clk);
      cs_n <= 1'b1;
      host_oe <= 1'b1;
      repeat (6) @(posedge ref_clk);
   endtask
endmodule

/* File: dv/tb_serial_cfg_and_system_timebase_input_pll_regs.sv */
// self-checking bench of the serial register bank against a shadow-register model
// assumes: spi_host_model drives the pins; clk_en dropped once while idle
`timescale 1ns/1ps
module tb_serial_cfg_and_system_timebase_input_pll_regs import serial_cfg_pkg::*; ();
   // ****************************************
   // signals and reference state
   // ****************************************
   localparam logic [BYTE_W-1:0] REV = 8'h3c; // arbitrary value
   localparam logic [BYTE_W-1:0] PID = 8'hc3; // arbitrary value
   logic ref_clk = 1'b0;
   logic arst_n = 1'b0;
   logic clk_en = 1'b1;
   logic [4:0] mf_pins_hi = 5'h00;
   logic sclk, cs_n, sdio_line, sdio_o, sdio_oe, sdo_o, sdo_oe;
   logic srp, nvm, four_w, lsb_f, ext_f, man, off;
   logic [2:0] code;
   logic [1:0] depth;
   logic [BYTE_W-1:0] fb;
   int err_count = 0, total_checks = 0, seed = 61, sr_cnt = 0, nvm_cnt = 0;
   int cfg_m, rb_m, pump_a, pump_b, div_a, div_b, v, dv;
   int adrs[10] = '{0, 1, 2, 3, 4, 5, 'h100, 'h101, 6, 'h1fff};
   int ro[5] = '{1, 2, 3, 6, 'h1fff};

   initial forever #12.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      if (srp) sr_cnt++;
      if (nvm) nvm_cnt++;
   end

   serial_cfg_and_system_timebase_input_pll_regs #(.REVISION_CODE(REV), .PART_CODE(PID)) dut_u (
      .ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en), .sclk(sclk), .cs_n(cs_n), .sdio_i(sdio_line),
      .sdio_o(sdio_o), .sdio_oe(sdio_oe), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .mf_pins_hi(mf_pins_hi),
      .soft_reset_pulse(srp), .nvm_download_start(nvm), .four_wire_mode(four_w), .lsb_first_mode(lsb_f),
      .ext_loop_filter(ext_f), .pump_manual(man), .pump_current_code(code), .lock_timer_off(off),
      .lock_timer_depth(depth), .fb_divide(fb));
   spi_host_model host_u (.ref_clk(ref_clk), .sclk(sclk), .cs_n(cs_n), .sdio_line(sdio_line),
      .sdio_o(sdio_o), .sdio_oe(sdio_oe), .sdo_o(sdo_o), .sdo_oe(sdo_oe));

   // ****************************************
   // model, compares and bus tasks
   // ****************************************
   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic report(input logic bad, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (bad) begin
         err_count++;
         $display("[FAIL] %0t exp %h got %h", $time, e, g);
      end
   endtask
   task automatic chk_rd(input logic [BYTE_W:0] e, input logic [BYTE_W:0] g);
      report(g !== e, 32'(e), 32'(g));
   endtask
   task automatic chk_out();
      logic [17:0] e, g;
      e = {cfg_m[7:6], pump_a[7:0], div_a[7:0]};
      g = {four_w, lsb_f, ext_f, man, code, off, depth, fb};
      report(g !== e, 32'(e), 32'(g));
   endtask
   task automatic chk_cnt(input int e, input int g);
      report(g != e, e, g);
   endtask
   task automatic dflt();
      cfg_m = 0;
      rb_m = 0;
      pump_a = 'h18; // code 011 in bits 5:3
      pump_b = 'h18;
      div_a = 'h28;
      div_b = 'h28;
   endtask
   task automatic upd(input int a, input int d);
      d = d & 'hff;
      case (a)
         ADR_SERIAL_CFG: if (d[5]) dflt(); else cfg_m = d & 'hc0;
         ADR_READBACK: rb_m = d & 1;
         ADR_XFER_STROBE: if (d[0]) begin
            pump_a = pump_b;
            div_a = div_b;
         end
         ADR_PLL_PUMP_LOCK: pump_b = d;
         ADR_PLL_FB_RATIO: div_b = d;
         default: ;
      endcase
      host_u.lsb = cfg_m[6];
      host_u.four = cfg_m[7];
   endtask
   function automatic logic [BYTE_W-1:0] exp_rd(input int a);
      int r;
      case (a)
         ADR_SERIAL_CFG: r = cfg_m | 'h10;
         ADR_SILICON_REV: r = REV;
         ADR_PART_ID: r = PID;
         ADR_READBACK: r = rb_m;
         ADR_PLL_PUMP_LOCK: r = rb_m ? pump_b : pump_a;
         ADR_PLL_FB_RATIO: r = rb_m ? div_b : div_a;
         default: r = 0;
      endcase
      return r[7:0];
   endfunction
   task automatic wr(input int a, input int d);
      host_u.tx_q.push_back(d[7:0]);
      host_u.frame(1'b0, a[12:0], 1);
      upd(a, d);
   endtask
   task automatic rd(input int a, input int n);
      host_u.frame(1'b1, a[12:0], n);
      for (int k = 0; k < n; k++) begin
         chk_rd({1'b1, exp_rd(cfg_m[6] ? a + k : a - k)}, host_u.rx_q.pop_front());
      end
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   initial begin
      dflt();
      repeat (6) @(posedge ref_clk);
      arst_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      chk_out();
      repeat (2) begin
         foreach (adrs[i]) rd(adrs[i], 1);
         foreach (ro[i]) wr(ro[i], $random(seed));
      end
      for (int i = 0; i < 8; i++) begin
         v = ($random(seed) & 'hc4) | (i << 3) | (i & 3);
         dv = 6 + {$random(seed)} % 250; // divider kept in 6..255
         wr(ADR_PLL_PUMP_LOCK, v);
         wr(ADR_PLL_FB_RATIO, dv);
         chk_out();
         wr(ADR_READBACK, (i & 1) | ($random(seed) & 'hfe));
         rd(ADR_PLL_FB_RATIO, 2);
         wr(ADR_XFER_STROBE, 1 | ($random(seed) & 'hfe));
         chk_out();
         rd(ADR_XFER_STROBE, 1);
      end
      rd(ADR_READBACK, 1);
      // frozen bank must hold every active value
      clk_en <= 1'b0;
      repeat (3 + {$random(seed)} % 8) @(posedge ref_clk);
      clk_en <= 1'b1;
      repeat (2) @(posedge ref_clk);
      chk_out();
      v = $random(seed);
      dv = 6 + {$random(seed)} % 250;
      host_u.tx_q.push_back(dv[7:0]);
      host_u.tx_q.push_back(v[7:0]);
      host_u.frame(1'b0, ADR_PLL_FB_RATIO, 2);
      upd(ADR_PLL_FB_RATIO, dv);
      upd(ADR_PLL_PUMP_LOCK, v);
      wr(ADR_XFER_STROBE, 1);
      chk_out();
      wr(ADR_SERIAL_CFG, 'h40);
      chk_out();
      rd(ADR_SILICON_REV, 2);
      wr(ADR_SERIAL_CFG, 'hc0);
      chk_out();
      rd(ADR_SERIAL_CFG, 1);
      rd(ADR_PLL_PUMP_LOCK, 1);
      mf_pins_hi <= 5'($random(seed)) | 5'h01;
      wr(ADR_SERIAL_CFG, 'he0);
      chk_cnt(1, sr_cnt);
      chk_cnt(1, nvm_cnt);
      chk_out();
      rd(ADR_PLL_FB_RATIO, 1);
      mf_pins_hi <= 5'h00;
      wr(ADR_SERIAL_CFG, 'h20);
      chk_cnt(2, sr_cnt);
      chk_cnt(1, nvm_cnt);
      results();
   end
   // bound well above the ~46k cycles the sequence needs
   initial begin
      repeat (90000) @(posedge ref_clk);
      err_count++;
      results();
   end
endmodule
